// ### rtl/dmc_pkg.sv
// package: register map, field layouts and types for one dma channel
package dmc_pkg;

    // register indices as printed; byte address is four times the index
    localparam logic [31:0] DMC_IDX_ITEM_INDEX = 32'h5000352E;
    localparam logic [31:0] DMC_IDX_SRC_LOW    = 32'h50003530;
    localparam logic [31:0] DMC_IDX_SRC_HIGH   = 32'h50003532;
    localparam logic [31:0] DMC_IDX_DST_LOW    = 32'h50003534;
    localparam logic [31:0] DMC_IDX_DST_HIGH   = 32'h50003536;
    localparam logic [31:0] DMC_IDX_IRQ_THRESH = 32'h50003538;
    localparam logic [31:0] DMC_IDX_XFER_LEN   = 32'h5000353A;
    localparam logic [31:0] DMC_IDX_CONTROL    = 32'h5000353C;
    localparam logic [31:0] DMC_IDX_IRQ_STATUS = 32'h50003540;
    localparam logic [31:0] DMC_IDX_IRQ_MASK   = 32'h50003541;

    // index bits that the decoder compares, taken from paddr[11:2]
    localparam int          DMC_DEC_W   = 10;
    localparam int          DMC_ADDR_LO = 2;

    // reset values
    localparam logic [15:0] DMC_RST_HALF   = 16'h0000;
    localparam logic [15:0] DMC_RST_CTRL   = 16'h0000;
    localparam logic [1:0]  DMC_RST_STATUS = 2'h0;
    localparam logic [1:0]  DMC_RST_MASK   = 2'h0;

    // interrupt status bit positions
    localparam int DMC_ST_THRESH = 0;
    localparam int DMC_ST_DONE   = 1;
    localparam int DMC_ST_W      = 2;

    // item size codes
    localparam logic [1:0] DMC_SIZE_BYTE = 2'h0;
    localparam logic [1:0] DMC_SIZE_HALF = 2'h1;
    localparam logic [1:0] DMC_SIZE_WORD = 2'h2;

    // address shift per size code
    localparam logic [1:0] DMC_SHIFT_BYTE = 2'h0;
    localparam logic [1:0] DMC_SHIFT_HALF = 2'h1;
    localparam logic [1:0] DMC_SHIFT_WORD = 2'h2;

    // control register layout, bit 15 down to bit 0
    typedef struct packed {
        logic [1:0] reserved;
        logic       req_edge;
        logic       init_fill;
        logic       idle_gap;
        logic [2:0] channel_rank;
        logic       circular;
        logic       src_addr_step_en;
        logic       dest_addr_step_en;
        logic       periph_trigger_sel;
        logic       irq_en;
        logic [1:0] item_size_sel;
        logic       chan_on;
    } dmc_ctrl_t;

    // one request toward the system bus
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [1:0]  size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } dmc_mem_req_t;

    // channel sequencer states, one-hot
    typedef enum logic [4:0] {
        DMC_S_IDLE  = 5'b00001,
        DMC_S_WAIT  = 5'b00010,
        DMC_S_READ  = 5'b00100,
        DMC_S_WRITE = 5'b01000,
        DMC_S_GAP   = 5'b10000
    } dmc_state_t;

endpackage

// ### rtl/dmc_channel.sv
// single dma channel: apb register file, item sequencer and interrupt logic
//
// Contract
// - destination steps by item size when enabled
// - start at once, or wait per peripheral request
// - interrupt only while interrupt enable set
// - size code: byte, halfword, word; 11 reserved
// - enable off means idle; on starts transfer
// - read-only item index counts stored items
// - item index returns to zero at completion
// - address is start plus scaled index
// - 32-bit starts in writable 16-bit halves
// - threshold equals index before increment raises interrupt
// - length holds item count minus one
// - circular only when triggered; restarts itself
// - source steps by item size when enabled
// - three-bit rank offered to bus arbiter
// - request sense: level or rising edge
module dmc_channel
    import dmc_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic               pclk,          // system clock, 40 MHz
    input  wire logic               presetn,       // async reset, active low
    input  wire logic               psel,          // apb select
    input  wire logic               penable,       // apb access phase
    input  wire logic               pwrite,        // apb direction, 1 = write
    input  wire logic [ADDR_W-1:0]  paddr,         // apb byte address
    input  wire logic [31:0]        pwdata,        // apb write data
    output logic      [31:0]        prdata,        // apb read data
    output logic                    pready,        // apb ready
    output logic                    pslverr,       // apb error, unmapped address
    output logic                    irq,           // level interrupt
    input  wire logic               periph_req,    // request from request mux
    output logic                    periph_ack,    // one-cycle pulse, request taken
    output logic [2:0]              channel_rank,  // rank toward the arbiter
    output logic                    bus_req,       // channel wants the bus
    input  wire logic               bus_grant,     // arbiter grants this channel
    output dmc_mem_req_t            mem_req,       // request toward memory
    input  wire logic               mem_ack,       // memory finished request
    input  wire logic [31:0]        mem_rdata,     // memory read data
    output logic                    chan_busy      // sequencer not idle
);

    // the decoder needs paddr[11:2]
    if (ADDR_W < DMC_DEC_W + DMC_ADDR_LO) begin : g_addr_w_chk
        $error("dmc_channel: ADDR_W too small for register decode");
    end

    // true when paddr selects the register with the given index
    function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [31:0] idx);
        addr_hit = (a[DMC_DEC_W+DMC_ADDR_LO-1:DMC_ADDR_LO] == idx[DMC_DEC_W-1:0])
                && (a[DMC_ADDR_LO-1:0] == '0);
    endfunction

    // byte offset of item idx for the given size code
    function automatic logic [31:0] item_offset(input logic [15:0] idx, input logic [1:0] sz);
        logic [31:0] wide;
        wide = {16'h0000, idx};
        unique case (sz)
            DMC_SIZE_BYTE: item_offset = wide << DMC_SHIFT_BYTE;
            DMC_SIZE_HALF: item_offset = wide << DMC_SHIFT_HALF;
            DMC_SIZE_WORD: item_offset = wide << DMC_SHIFT_WORD;
            default:       item_offset = wide << DMC_SHIFT_BYTE;   // reserved code
        endcase
    endfunction

    // registers
    logic [15:0]          src_low_r,  src_low_nxt;
    logic [15:0]          src_high_r, src_high_nxt;
    logic [15:0]          dst_low_r,  dst_low_nxt;
    logic [15:0]          dst_high_r, dst_high_nxt;
    logic [15:0]          thresh_r,   thresh_nxt;
    logic [15:0]          len_r,      len_nxt;
    logic [15:0]          index_r,    index_nxt;
    dmc_ctrl_t            ctrl_r,     ctrl_nxt;
    logic [DMC_ST_W-1:0]  status_r,   status_nxt;
    logic [DMC_ST_W-1:0]  mask_r,     mask_nxt;
    logic                 irq_r,      irq_nxt;
    logic [31:0]          prdata_r,   prdata_nxt;
    logic                 pready_r,   pready_nxt;
    logic                 pslverr_r,  pslverr_nxt;
    dmc_state_t           state_r,    state_nxt;
    dmc_mem_req_t         mem_r,      mem_nxt;
    logic [31:0]          data_r,     data_nxt;
    logic                 req_d1_r,   req_d1_nxt;
    logic                 edge_pend_r, edge_pend_nxt;
    logic                 ack_r,      ack_nxt;
    logic                 bus_req_r,  bus_req_nxt;
    logic                 busy_r,     busy_nxt;

    // combinational helpers
    logic [31:0] src_addr;
    logic [31:0] dst_addr;
    logic        req_seen;
    logic        mapped;
    logic        wr_commit;

    // item addresses from start plus scaled index
    always_comb begin
        src_addr = {src_high_r, src_low_r};
        dst_addr = {dst_high_r, dst_low_r};
        if (ctrl_r.src_addr_step_en) begin
            src_addr = src_addr + item_offset(index_r, ctrl_r.item_size_sel);
        end
        if (ctrl_r.dest_addr_step_en) begin
            dst_addr = dst_addr + item_offset(index_r, ctrl_r.item_size_sel);
        end
    end

    // request seen: raw level, or a latched rising edge
    assign req_seen = ctrl_r.req_edge ? edge_pend_r : periph_req;

    // address decode shared by read and write paths
    assign mapped = addr_hit(paddr, DMC_IDX_ITEM_INDEX) || addr_hit(paddr, DMC_IDX_SRC_LOW)
                 || addr_hit(paddr, DMC_IDX_SRC_HIGH)   || addr_hit(paddr, DMC_IDX_DST_LOW)
                 || addr_hit(paddr, DMC_IDX_DST_HIGH)   || addr_hit(paddr, DMC_IDX_IRQ_THRESH)
                 || addr_hit(paddr, DMC_IDX_XFER_LEN)   || addr_hit(paddr, DMC_IDX_CONTROL)
                 || addr_hit(paddr, DMC_IDX_IRQ_STATUS) || addr_hit(paddr, DMC_IDX_IRQ_MASK);

    // a write lands at the access edge where pready is high
    assign wr_commit = psel && penable && pready_r && pwrite && mapped;

    // next values of every register; bus writes first, hardware updates after
    always_comb begin
        src_low_nxt   = src_low_r;
        src_high_nxt  = src_high_r;
        dst_low_nxt   = dst_low_r;
        dst_high_nxt  = dst_high_r;
        thresh_nxt    = thresh_r;
        len_nxt       = len_r;
        index_nxt     = index_r;
        ctrl_nxt      = ctrl_r;
        status_nxt    = status_r;
        mask_nxt      = mask_r;
        state_nxt     = state_r;
        mem_nxt       = mem_r;
        data_nxt      = data_r;
        req_d1_nxt    = periph_req;
        edge_pend_nxt = edge_pend_r;
        ack_nxt       = 1'b0;
        prdata_nxt    = 32'h0000_0000;
        pready_nxt    = 1'b0;
        pslverr_nxt   = 1'b0;

        // setup phase: prepare the answer so the access phase needs no wait
        if (psel && !penable) begin
            pready_nxt  = 1'b1;
            pslverr_nxt = !mapped;
            if (addr_hit(paddr, DMC_IDX_ITEM_INDEX)) prdata_nxt[15:0] = index_r;
            if (addr_hit(paddr, DMC_IDX_SRC_LOW))    prdata_nxt[15:0] = src_low_r;
            if (addr_hit(paddr, DMC_IDX_SRC_HIGH))   prdata_nxt[15:0] = src_high_r;
            if (addr_hit(paddr, DMC_IDX_DST_LOW))    prdata_nxt[15:0] = dst_low_r;
            if (addr_hit(paddr, DMC_IDX_DST_HIGH))   prdata_nxt[15:0] = dst_high_r;
            if (addr_hit(paddr, DMC_IDX_IRQ_THRESH)) prdata_nxt[15:0] = thresh_r;
            if (addr_hit(paddr, DMC_IDX_XFER_LEN))   prdata_nxt[15:0] = len_r;
            if (addr_hit(paddr, DMC_IDX_CONTROL))    prdata_nxt[15:0] = ctrl_r;
            if (addr_hit(paddr, DMC_IDX_IRQ_STATUS)) prdata_nxt[DMC_ST_W-1:0] = status_r;
            if (addr_hit(paddr, DMC_IDX_IRQ_MASK))   prdata_nxt[DMC_ST_W-1:0] = mask_r;
        end

        // register writes; the item index has no write path
        if (wr_commit) begin
            if (addr_hit(paddr, DMC_IDX_SRC_LOW))    src_low_nxt  = pwdata[15:0];
            if (addr_hit(paddr, DMC_IDX_SRC_HIGH))   src_high_nxt = pwdata[15:0];
            if (addr_hit(paddr, DMC_IDX_DST_LOW))    dst_low_nxt  = pwdata[15:0];
            if (addr_hit(paddr, DMC_IDX_DST_HIGH))   dst_high_nxt = pwdata[15:0];
            if (addr_hit(paddr, DMC_IDX_IRQ_THRESH)) thresh_nxt   = pwdata[15:0];
            if (addr_hit(paddr, DMC_IDX_XFER_LEN))   len_nxt      = pwdata[15:0];
            if (addr_hit(paddr, DMC_IDX_CONTROL)) begin
                ctrl_nxt          = dmc_ctrl_t'(pwdata[15:0]);
                ctrl_nxt.reserved = 2'h0;                     // reserved bits read zero
            end
            if (addr_hit(paddr, DMC_IDX_IRQ_STATUS)) begin
                status_nxt = status_r & ~pwdata[DMC_ST_W-1:0];   // write one to clear
            end
            if (addr_hit(paddr, DMC_IDX_IRQ_MASK))   mask_nxt = pwdata[DMC_ST_W-1:0];
        end

        // latch rising edges while on; the set is applied after the clear
        if (state_r == DMC_S_WAIT && ctrl_r.req_edge && edge_pend_r) begin
            edge_pend_nxt = 1'b0;
        end
        if (periph_req && !req_d1_r && ctrl_r.chan_on && ctrl_r.req_edge) begin
            edge_pend_nxt = 1'b1;
        end

        // channel sequencer
        unique case (state_r)
            DMC_S_IDLE: begin
                if (ctrl_r.chan_on) begin
                    state_nxt = ctrl_r.periph_trigger_sel ? DMC_S_WAIT : DMC_S_READ;
                end
            end
            DMC_S_WAIT: begin
                // one item per accepted request
                if (req_seen) begin
                    ack_nxt   = 1'b1;
                    state_nxt = DMC_S_READ;
                end
            end
            DMC_S_READ: begin
                // fill mode fetches the source only for the first item
                if (ctrl_r.init_fill && index_r != 16'h0000 && !mem_r.valid) begin
                    state_nxt = DMC_S_WRITE;
                end else if (!mem_r.valid && bus_grant) begin
                    mem_nxt.valid = 1'b1;
                    mem_nxt.write = 1'b0;
                    mem_nxt.size  = ctrl_r.item_size_sel;
                    mem_nxt.addr  = src_addr;
                    mem_nxt.wdata = 32'h0000_0000;
                end else if (mem_r.valid && mem_ack) begin
                    mem_nxt.valid = 1'b0;
                    data_nxt      = mem_rdata;
                    state_nxt     = DMC_S_WRITE;
                end
            end
            DMC_S_WRITE: begin
                if (!mem_r.valid && bus_grant) begin
                    mem_nxt.valid = 1'b1;
                    mem_nxt.write = 1'b1;
                    mem_nxt.size  = ctrl_r.item_size_sel;
                    mem_nxt.addr  = dst_addr;
                    mem_nxt.wdata = data_r;
                end else if (mem_r.valid && mem_ack) begin
                    mem_nxt.valid = 1'b0;
                    // threshold compared against the index before it steps
                    if (thresh_r == index_r && ctrl_r.irq_en) begin
                        status_nxt[DMC_ST_THRESH] = 1'b1;
                    end
                    if (index_r == len_r) begin
                        index_nxt = 16'h0000;
                        if (ctrl_r.irq_en) begin
                            status_nxt[DMC_ST_DONE] = 1'b1;
                        end
                        if (ctrl_r.circular && ctrl_r.periph_trigger_sel) begin
                            state_nxt = DMC_S_WAIT;
                        end else begin
                            ctrl_nxt.chan_on = 1'b0;
                            state_nxt        = DMC_S_IDLE;
                        end
                    end else begin
                        index_nxt = index_r + 16'h0001;
                        if (ctrl_r.periph_trigger_sel) begin
                            state_nxt = DMC_S_WAIT;
                        end else if (ctrl_r.idle_gap) begin
                            state_nxt = DMC_S_GAP;
                        end else begin
                            state_nxt = DMC_S_READ;
                        end
                    end
                end
            end
            DMC_S_GAP: begin
                // one free bus cycle after each store for other masters
                state_nxt = DMC_S_READ;
            end
        endcase

        // switching the channel off parks it once no bus request is open
        if (!ctrl_r.chan_on && !mem_r.valid && state_r != DMC_S_IDLE) begin
            state_nxt     = DMC_S_IDLE;
            edge_pend_nxt = 1'b0;
        end

        bus_req_nxt = (state_nxt == DMC_S_READ) || (state_nxt == DMC_S_WRITE);
        busy_nxt    = (state_nxt != DMC_S_IDLE);
        irq_nxt     = |(status_nxt & mask_nxt);
    end

    // registers only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_low_r   <= DMC_RST_HALF;
            src_high_r  <= DMC_RST_HALF;
            dst_low_r   <= DMC_RST_HALF;
            dst_high_r  <= DMC_RST_HALF;
            thresh_r    <= DMC_RST_HALF;
            len_r       <= DMC_RST_HALF;
            index_r     <= DMC_RST_HALF;
            ctrl_r      <= dmc_ctrl_t'(DMC_RST_CTRL);
            status_r    <= DMC_RST_STATUS;
            mask_r      <= DMC_RST_MASK;
            irq_r       <= 1'b0;
            prdata_r    <= 32'h0000_0000;
            pready_r    <= 1'b0;
            pslverr_r   <= 1'b0;
            state_r     <= DMC_S_IDLE;
            mem_r       <= '0;
            data_r      <= 32'h0000_0000;
            req_d1_r    <= 1'b0;
            edge_pend_r <= 1'b0;
            ack_r       <= 1'b0;
            bus_req_r   <= 1'b0;
            busy_r      <= 1'b0;
        end else begin
            src_low_r   <= src_low_nxt;
            src_high_r  <= src_high_nxt;
            dst_low_r   <= dst_low_nxt;
            dst_high_r  <= dst_high_nxt;
            thresh_r    <= thresh_nxt;
            len_r       <= len_nxt;
            index_r     <= index_nxt;
            ctrl_r      <= ctrl_nxt;
            status_r    <= status_nxt;
            mask_r      <= mask_nxt;
            irq_r       <= irq_nxt;
            prdata_r    <= prdata_nxt;
            pready_r    <= pready_nxt;
            pslverr_r   <= pslverr_nxt;
            state_r     <= state_nxt;
            mem_r       <= mem_nxt;
            data_r      <= data_nxt;
            req_d1_r    <= req_d1_nxt;
            edge_pend_r <= edge_pend_nxt;
            ack_r       <= ack_nxt;
            bus_req_r   <= bus_req_nxt;
            busy_r      <= busy_nxt;
        end
    end

    // outputs straight from flops
    assign prdata       = prdata_r;
    assign pready       = pready_r;
    assign pslverr      = pslverr_r;
    assign irq          = irq_r;
    assign periph_ack   = ack_r;
    assign channel_rank = ctrl_r.channel_rank;
    assign bus_req      = bus_req_r;
    assign mem_req      = mem_r;
    assign chan_busy    = busy_r;

endmodule

// ### testbench/dmc_channel_monitor.sv
// checker: timing relations on the dma channel ports
module dmc_channel_monitor
    import dmc_pkg::*;
(
    input wire logic         pclk,         // clock
    input wire logic         presetn,      // reset, low
    input wire logic         psel,         // select
    input wire logic         penable,      // access
    input wire logic         pwrite,       // write
    input wire logic         pready,       // ready
    input wire logic         pslverr,      // error
    input wire logic         periph_ack,   // taken
    input wire logic [2:0]   channel_rank, // rank
    input wire logic         bus_req,      // wants bus
    input wire logic         bus_grant,    // granted
    input wire dmc_mem_req_t mem_req,      // request
    input wire logic         mem_ack,      // answered
    input wire logic         chan_busy     // not idle
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // bus answers and memory handshakes
    a_ready_one_cycle: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("ready not a single cycle");
    a_req_held: assert property (mem_req.valid && !mem_ack |=> $stable(mem_req))
        else $error("request changed before answer");
    a_valid_drops: assert property (mem_req.valid && mem_ack |=> !mem_req.valid)
        else $error("request kept after answer");
    a_grant_first: assert property ($rose(mem_req.valid) |-> $past(bus_grant))
        else $error("request without grant");
    // rank moves only by a register write; an idle channel stays off the bus
    a_rank_steady: assert property (!(psel && penable && pwrite) |=> $stable(channel_rank))
        else $error("rank moved without write");
    a_idle_quiet: assert property (!chan_busy |-> !bus_req && !mem_req.valid)
        else $error("idle channel on bus");
    a_ack_pulse: assert property (periph_ack |=> !periph_ack)
        else $error("accept longer than a cycle");
    a_ack_moves: assert property (periph_ack |-> ##[0:2] bus_req)
        else $error("accepted request moved nothing");
    c_slverr: cover property (pslverr);
    c_periph: cover property (periph_ack);
    c_store: cover property (mem_req.valid && mem_req.write && mem_ack);
endmodule

// ### testbench/dmc_mem_model.sv
// far side model: bus grant and a memory answering at a chosen latency
module dmc_mem_model
    import dmc_pkg::*;
(
    input  wire logic         pclk,      // clock
    input  wire logic         presetn,   // reset, low
    input  wire logic         bus_req,   // bus wanted
    input  wire dmc_mem_req_t mem_req,   // request
    input  wire logic [3:0]   wait_cyc,  // answer delay
    output logic              bus_grant, // sole channel, granted
    output logic              mem_ack,   // answer
    output logic      [31:0]  mem_rdata  // read data
);
    logic [3:0] cnt_r;
    // one answer per request; data churns otherwise so stale reads show
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r     <= 4'h0;
            bus_grant <= 1'b0;
            mem_ack   <= 1'b0;
            mem_rdata <= 32'h0;
        end else begin
            bus_grant <= bus_req;
            mem_ack   <= 1'b0;
            mem_rdata <= ~mem_rdata;
            cnt_r     <= 4'h0;
            if (mem_req.valid && !mem_ack && cnt_r < wait_cyc)
                cnt_r <= cnt_r + 4'h1;
            else if (mem_req.valid && !mem_ack) begin
                mem_ack   <= 1'b1;
                mem_rdata <= mem_req.addr ^ 32'hA5A5A5A5;
            end
        end
    end
endmodule

// ### testbench/dmc_channel_bench.sv
// testbench: registers, transfers, peripheral requests, interrupt
module dmc_channel_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import dmc_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic periph_req = 1'b0, pready, pslverr, irq, periph_ack, bus_req, bus_grant;
    logic mem_ack, chan_busy, x_sinc, x_dinc, e;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, mem_rdata, x_src, x_dst, q;
    logic [15:0] rnd = 16'h4C9B, ctl, st;
    logic [3:0]  wait_cyc = 4'h0;
    logic [2:0]  channel_rank;
    logic [1:0]  x_sz = 2'h0;
    dmc_mem_req_t mem_req;
    int fails = 0, tests_run = 0, it_cnt = 0;
    // 40 MHz
    always #12.5 pclk = ~pclk;
    dmc_channel #(.ADDR_W(12)) uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .irq, .periph_req, .periph_ack, .channel_rank,
        .bus_req, .bus_grant, .mem_req, .mem_ack, .mem_rdata, .chan_busy);
    dmc_mem_model far (.pclk, .presetn, .bus_req, .mem_req, .wait_cyc, .bus_grant,
        .mem_ack, .mem_rdata);
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // register byte address; printed indices step by two, own ones by one
    function automatic logic [11:0] ra(input logic [31:0] idx);
        return {idx[9:0], 2'h0};
    endfunction
    function automatic logic [31:0] ix(input int i);
        return i < 8 ? DMC_IDX_ITEM_INDEX + 32'(2 * i) : DMC_IDX_IRQ_STATUS + 32'(i - 8);
    endfunction
    function automatic logic [31:0] off(input logic inc);
        return inc ? 32'(it_cnt) << x_sz : 32'h0;
    endfunction
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // one apb transfer; bounded wait for ready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) fails++;
        if (n >= 16) complete_run;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(nm, q, x);
    endtask
    // bounded wait: 0 channel idle, 1 request taken, 2 bus released
    task automatic await(input int sel);
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (n < 400 && ((n < 3 && sel != 1) ||
                   (sel == 0 ? chan_busy : sel == 1 ? !periph_ack : bus_req) !== 1'b0));
        if (n >= 400) fails++;
        if (n >= 400) complete_run;
    endtask
    task automatic preq;
        periph_req <= 1'b1;
        await(1);
        periph_req <= 1'b0;
        await(2);
    endtask
    // each finished memory request vs the pointers
    always @(posedge pclk) begin
        if (presetn && mem_req.valid && mem_ack && !mem_req.write) begin
            chk("src addr", mem_req.addr, x_src + off(x_sinc));
        end else if (presetn && mem_req.valid && mem_ack) begin
            chk("dst addr", mem_req.addr, x_dst + off(x_dinc));
            chk("data", mem_req.wdata, (x_src + off(x_sinc)) ^ 32'hA5A5A5A5);
            chk("size", {30'h0, mem_req.size}, {30'h0, x_sz});
            it_cnt++;
        end
    end
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 10; i++)
            rdc("reset", ra(ix(i)), 32'h0);
        for (int i = 0; i < 7; i++) begin
            rnd = lfsr(rnd);
            apb(1'b1, ra(ix(i)), {16'hFFFF, rnd});
            rdc("half", ra(ix(i)), i == 0 ? 32'h0 : {16'h0, rnd});
        end
        rdc("unmapped", 12'h7FC, 32'h0);
        chk("slverr", {31'h0, e}, 32'h1);
        // immediate transfers: each size, random steps, gap, delay, rank
        for (int t = 0; t < 6; t++) begin
            rnd = lfsr(rnd);
            x_sz = 2'(t % 3);
            x_sinc = rnd[0];
            x_dinc = rnd[1];
            x_src = {rnd, ~rnd} & 32'hFFFFFFFC;
            x_dst = {~rnd, rnd} & 32'hFFFFFFFC;
            wait_cyc <= rnd[11:8];
            ctl = {4'h0, rnd[12], rnd[15:13], 1'b0, x_sinc, x_dinc, 1'b0, t != 5, x_sz, 1'b1};
            apb(1'b1, ra(DMC_IDX_SRC_LOW), {16'h0, x_src[15:0]});
            apb(1'b1, ra(DMC_IDX_SRC_HIGH), {16'h0, x_src[31:16]});
            apb(1'b1, ra(DMC_IDX_DST_LOW), {16'h0, x_dst[15:0]});
            apb(1'b1, ra(DMC_IDX_DST_HIGH), {16'h0, x_dst[31:16]});
            apb(1'b1, ra(DMC_IDX_IRQ_THRESH), {30'h0, rnd[7:6]});
            apb(1'b1, ra(DMC_IDX_XFER_LEN), {30'h0, rnd[5:4]});
            apb(1'b1, ra(DMC_IDX_IRQ_MASK), {30'h0, {2{t != 4}}});
            it_cnt = 0;
            apb(1'b1, ra(DMC_IDX_CONTROL), {16'h0, ctl});
            await(0);
            chk("items", it_cnt, 32'(rnd[5:4]) + 32'h1);
            chk("rank", {29'h0, channel_rank}, {29'h0, ctl[10:8]});
            rdc("self clear", ra(DMC_IDX_CONTROL), {16'h0, ctl & 16'hFFFE});
            rdc("index", ra(DMC_IDX_ITEM_INDEX), 32'h0);
            st = t == 5 ? 16'h0 : {14'h0, 1'b1, rnd[7:6] <= rnd[5:4]};
            rdc("status", ra(DMC_IDX_IRQ_STATUS), {16'h0, st});
            chk("irq", {31'h0, irq}, {31'h0, st != 16'h0 && t != 4});
            apb(1'b1, ra(DMC_IDX_IRQ_STATUS), 32'h3);
            rdc("cleared", ra(DMC_IDX_IRQ_STATUS), 32'h0);
            chk("irq low", {31'h0, irq}, 32'h0);
        end
        // level requests: nothing moves unasked, one item each
        {x_sinc, x_dinc, x_sz, it_cnt} = '0;
        wait_cyc <= 4'h2;
        apb(1'b1, ra(DMC_IDX_XFER_LEN), 32'h1);
        apb(1'b1, ra(DMC_IDX_CONTROL), 32'h0011);
        repeat (8) @(posedge pclk);
        chk("unasked", {31'h0, bus_req}, 32'h0);
        preq;
        preq;
        await(0);
        chk("two items", it_cnt, 32'h2);
        // edge sensing: a request held high counts once
        it_cnt = 0;
        apb(1'b1, ra(DMC_IDX_CONTROL), 32'h2011);
        periph_req <= 1'b1;
        repeat (60) @(posedge pclk);
        chk("edge once", it_cnt, 32'h1);
        periph_req <= 1'b0;
        @(posedge pclk);
        preq;
        await(0);
        chk("edge items", it_cnt, 32'h2);
        // circular: restarts alone and stays on
        it_cnt = 0;
        apb(1'b1, ra(DMC_IDX_XFER_LEN), 32'h0);
        apb(1'b1, ra(DMC_IDX_CONTROL), 32'h0091);
        preq;
        preq;
        chk("circ items", it_cnt, 32'h2);
        rdc("still on", ra(DMC_IDX_CONTROL), 32'h0091);
        apb(1'b1, ra(DMC_IDX_CONTROL), 32'h0);
        await(0);
        complete_run;
    end
endmodule
bind dmc_channel dmc_channel_monitor mon (.pclk, .presetn, .psel, .penable, .pwrite, .pready,
    .pslverr, .periph_ack, .channel_rank, .bus_req, .bus_grant, .mem_req, .mem_ack, .chan_busy);
